/* src/wdog_pkg.sv */
// Purpose: constants for the windowed watchdog register block
// Assumes: registers one per aligned 32-bit word, byte address = 4 * index
// Notes:   reset values are loaded from config fields after reset release
package wdog_pkg;
  // register indices, byte address is index times four
  localparam logic [15:0] IDX_CTRL0    = 16'h0ECD;
  localparam logic [15:0] IDX_CTRL1    = 16'h0ECE;
  localparam logic [15:0] IDX_PSC_LOW  = 16'h0ECF;
  localparam logic [15:0] IDX_PSC_HIGH = 16'h0ED0;
  localparam logic [15:0] IDX_TMR      = 16'h0ED1;
  // field positions
  localparam int SEN_BIT    = 0;
  localparam int PS_LSB     = 1;
  localparam int WIN_LSB    = 0;
  localparam int TB_LSB     = 4;
  localparam int ARMED_BIT  = 2;
  localparam int WTMR_LSB   = 3;
  // period select codes
  localparam logic [4:0] PS_CFG_SOFT  = 5'h1F;
  localparam logic [4:0] PS_DEFAULT   = 5'h0B;
  localparam logic [4:0] PS_MAX_LEGAL = 5'h12;
  // timebase and window codes
  localparam logic [2:0] TB_CFG_SOFT  = 3'h7;
  localparam logic [2:0] TB_LF        = 3'h0;
  localparam logic [2:0] TB_MF        = 3'h1;
  localparam logic [2:0] WIN_FULL     = 3'h7;
  // reset values and last window timer value
  localparam logic       SEN_RESET    = 1'h0;
  localparam logic [4:0] PS_RESET     = 5'h0B;
  localparam logic [2:0] TB_RESET     = 3'h0;
  localparam logic [2:0] WIN_RESET    = 3'h7;
  localparam logic [4:0] WTMR_LAST    = 5'h1F;
  // operating modes of the mode config field
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_SOFT    = 2'h1;
  // bus answers
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

/* src/wdog_regs.sv */
// Purpose: windowed watchdog counters and control registers, AXI4-Lite slave
// Assumes: oscillator ticks are one-cycle pulses synchronous to core_clk
// Notes:   one write and one read in flight at most; no sleep handling
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - period codes 0..18 give ratio 32 doubling
// - period codes 19..31 give minimum interval
// - period reset: default code or config copy
// - period field read-only unless config is 31
// - soft enable only counts in mode 01
// - timebase 000 low osc, 001 mid osc
// - timebase reset: 000 or config copy; read-only unless config 111
// - window code sets open fraction in eighths
// - window reset from config; read-only unless 111
// - status bits 7:3 show window timer
// - status bit 2 shows armed state
// - 18-bit prescale counter readable in three parts
// - prescale low byte read-only, resets zero
// - interval counts selected timebase tick through ratio
// - windowed clear needs prior arming read
// - clear in closed window causes reset
// - control register writes clear counters
// - missing valid clear before timeout resets
module wdog_regs (
  // clock and reset
  input  wire  logic        core_clk,
  input  wire  logic        rstn,
  // configuration word fields
  input  wire  logic [1:0]  wdog_mode_cfg,
  input  wire  logic [4:0]  cfg_period_field,
  input  wire  logic [2:0]  cfg_timebase_field,
  input  wire  logic [2:0]  cfg_window_field,
  // oscillator ticks and clear instruction
  input  wire  logic        low_freq_osc,
  input  wire  logic        mid_freq_osc,
  input  wire  logic        wdog_clear_instr,
  // watchdog outputs
  output logic              wdog_reset,
  output logic              wdog_active,
  // axi4-lite write channels
  input  wire  logic [15:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // axi4-lite read channels
  input  wire  logic [15:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready
);

  // decode a byte address into a register hit
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a[15:2] == idx[13:0]) && (a[1:0] == 2'h0);
  endfunction

  // prescale wrap value for a period code; reserved codes use the shortest
  function automatic logic [17:0] psc_top(input logic [4:0] ps);
    logic [4:0] sh;
    sh = (ps > wdog_pkg::PS_MAX_LEGAL) ? 5'h00 : ps;
    psc_top = 18'((19'h00001 << sh) - 19'h00001);
  endfunction

  // reset synchroniser
  logic        rst_meta_reg;
  logic        rst_n_sync;

  // control state
  logic        init_reg;        // first cycle after release loads config
  logic        sen_reg;         // soft enable
  logic [4:0]  ps_reg;          // period select
  logic [2:0]  tb_reg;          // timebase select
  logic [2:0]  win_reg;         // window select
  logic        armed_reg;       // armed by a control 0 read
  logic [17:0] psc_reg;         // prescale counter
  logic [4:0]  wtmr_reg;        // window timer
  logic        rst_out_reg;     // watchdog reset pulse

  // bus state
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  // release of reset through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // write path decode; address and data are taken together
  wire wr_fire  = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  wire wr_c0    = wr_fire && hit(s_axi_awaddr, wdog_pkg::IDX_CTRL0);
  wire wr_c1    = wr_fire && hit(s_axi_awaddr, wdog_pkg::IDX_CTRL1);
  wire wr_known = wr_c0 || wr_c1 ||
                  hit(s_axi_awaddr, wdog_pkg::IDX_PSC_LOW) ||
                  hit(s_axi_awaddr, wdog_pkg::IDX_PSC_HIGH) ||
                  hit(s_axi_awaddr, wdog_pkg::IDX_TMR);
  // a write with byte lane 0 off still clears the counters
  wire wr_ctrl  = wr_c0 || wr_c1;
  wire wr_lane0 = s_axi_wstrb[0];

  // read path decode
  wire rd_fire  = s_axi_arvalid && !rvalid_reg;
  wire rd_c0    = hit(s_axi_araddr, wdog_pkg::IDX_CTRL0);
  wire rd_c1    = hit(s_axi_araddr, wdog_pkg::IDX_CTRL1);
  wire rd_pl    = hit(s_axi_araddr, wdog_pkg::IDX_PSC_LOW);
  wire rd_ph    = hit(s_axi_araddr, wdog_pkg::IDX_PSC_HIGH);
  wire rd_tm    = hit(s_axi_araddr, wdog_pkg::IDX_TMR);
  wire rd_known = rd_c0 || rd_c1 || rd_pl || rd_ph || rd_tm;
  wire arm_rd   = rd_fire && rd_c0;

  // write permission follows the config fields
  wire ps_wr_ok  = (cfg_period_field == wdog_pkg::PS_CFG_SOFT);
  wire tb_wr_ok  = (cfg_timebase_field == wdog_pkg::TB_CFG_SOFT);
  wire win_wr_ok = (cfg_window_field == wdog_pkg::WIN_FULL);

  // reset values derived from config
  wire [4:0] ps_init  = ps_wr_ok ? wdog_pkg::PS_DEFAULT
                                 : cfg_period_field;
  wire [2:0] tb_init  = tb_wr_ok ? wdog_pkg::TB_LF
                                 : cfg_timebase_field;
  wire [2:0] win_init = cfg_window_field;

  // enable by mode; soft enable matters only in soft mode
  wire active = (wdog_mode_cfg == wdog_pkg::MODE_SOFT) ? sen_reg
              : (wdog_mode_cfg != wdog_pkg::MODE_OFF);

  // timebase tick; reserved codes fall back to the low oscillator
  wire tick = active && ((tb_reg == wdog_pkg::TB_MF) ? mid_freq_osc
                                                     : low_freq_osc);

  // window open when the timer top bits reach the open start
  wire windowed = (win_reg != wdog_pkg::WIN_FULL);
  wire win_open = (wtmr_reg[4:2] >= ~win_reg);

  // clear instruction outcome
  wire clr_seen  = wdog_clear_instr && active;
  wire violation = clr_seen && windowed && (!armed_reg || !win_open);
  wire clr_ok    = clr_seen && !violation;

  // full period reached
  wire [17:0] top  = psc_top(ps_reg);
  wire psc_wrap    = (psc_reg == top);
  wire timeout     = tick && psc_wrap && (wtmr_reg == wdog_pkg::WTMR_LAST);

  // every cause that restarts the count
  wire cnt_clear = !active || clr_ok || wr_ctrl || timeout || violation;

  // read mux
  wire [7:0] c0_val = {2'h0, ps_reg, sen_reg};
  wire [7:0] c1_val = {1'h0, tb_reg, 1'h0, win_reg};
  wire [7:0] tm_val = {wtmr_reg, armed_reg, psc_reg[17:16]};
  wire [7:0] rd_val = rd_c0 ? c0_val
                    : rd_c1 ? c1_val
                    : rd_pl ? psc_reg[7:0]
                    : rd_ph ? psc_reg[15:8]
                    : rd_tm ? tm_val : 8'h00;

  // handshake outputs
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign wdog_reset    = rst_out_reg;
  assign wdog_active   = active;

  // control fields: constants at reset, config copy on the first cycle
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      init_reg <= 1'b1;
      sen_reg  <= wdog_pkg::SEN_RESET;
      ps_reg   <= wdog_pkg::PS_RESET;
      tb_reg   <= wdog_pkg::TB_RESET;
      win_reg  <= wdog_pkg::WIN_RESET;
    end else if (init_reg) begin
      init_reg <= 1'b0;
      ps_reg   <= ps_init;
      tb_reg   <= tb_init;
      win_reg  <= win_init;
    end else begin
      // soft enable is kept in every mode, it only acts in soft mode
      if (wr_c0 && wr_lane0) begin
        sen_reg <= s_axi_wdata[wdog_pkg::SEN_BIT];
      end
      if (wr_c0 && wr_lane0 && ps_wr_ok) begin
        ps_reg <= s_axi_wdata[wdog_pkg::PS_LSB +: 5];
      end
      if (wr_c1 && wr_lane0 && tb_wr_ok) begin
        tb_reg <= s_axi_wdata[wdog_pkg::TB_LSB +: 3];
      end
      if (wr_c1 && wr_lane0 && win_wr_ok) begin
        win_reg <= s_axi_wdata[wdog_pkg::WIN_LSB +: 3];
      end
    end
  end

  // prescale counter and window timer
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      psc_reg  <= 18'h00000;
      wtmr_reg <= 5'h00;
    end else if (cnt_clear) begin
      psc_reg  <= 18'h00000;
      wtmr_reg <= 5'h00;
    end else if (tick && psc_wrap) begin
      psc_reg  <= 18'h00000;
      wtmr_reg <= wtmr_reg + 5'h01;
    end else if (tick) begin
      psc_reg  <= psc_reg + 18'h00001;
    end
  end

  // armed flag; an arming read in the clearing cycle still wins
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      armed_reg <= 1'b0;
    end else if (arm_rd) begin
      armed_reg <= 1'b1;
    end else if (cnt_clear) begin
      armed_reg <= 1'b0;
    end
  end

  // reset request, one cycle per timeout or violation
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rst_out_reg <= 1'b0;
    end else begin
      rst_out_reg <= timeout || violation;
    end
  end

  // write response; unmapped addresses answer slave error
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= wdog_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_known ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read data, captured at the address handshake
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= wdog_pkg::RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_known ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
      rdata_reg  <= {24'h000000, rd_val};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // checks on the watchdog behaviour

  a_period_ratio: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (ps_reg <= wdog_pkg::PS_MAX_LEGAL) |-> (19'(top) + 19'h1 == (19'h1 << ps_reg)))
    else $error("prescale wrap does not match period code");

  a_period_reserved: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (ps_reg > wdog_pkg::PS_MAX_LEGAL) |-> (top == 18'h00000))
    else $error("reserved period code not at minimum");

  // the release edge itself still runs the reset branch, so only later edges load
  a_period_reset: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (init_reg && rst_n_sync) |=> (ps_reg == $past(ps_init)))
    else $error("period select reset value wrong");

  a_period_locked: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (!init_reg && !ps_wr_ok) |=> $stable(ps_reg))
    else $error("locked period select changed");

  a_mode_enable: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (wdog_mode_cfg == wdog_pkg::MODE_OFF) |-> (!wdog_active && psc_reg == 18'h0 ##1 psc_reg == 18'h0))
    else $error("watchdog counts in off mode");

  a_timebase_locked: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (!init_reg && !tb_wr_ok) |=> $stable(tb_reg))
    else $error("locked timebase changed");

  a_window_locked: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (!init_reg && !win_wr_ok) |=> $stable(win_reg))
    else $error("locked window changed");

  a_bad_clear: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (clr_seen && windowed && !win_open) |=> (wdog_reset && wtmr_reg == 5'h00))
    else $error("clear in closed window not punished");

  a_unarmed_clear: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (clr_seen && windowed && !armed_reg) |=> wdog_reset)
    else $error("unarmed clear not punished");

  a_ctrl_write: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (wr_ctrl && !init_reg) |=> (psc_reg == 18'h0 && wtmr_reg == 5'h00))
    else $error("control write did not clear counters");

  a_timeout_restart: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    timeout |=> (wdog_reset && psc_reg == 18'h0 && wtmr_reg == 5'h00) ##1 !wdog_reset)
    else $error("timeout did not reset and restart");

  a_arm_drop: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (cnt_clear && !arm_rd) |=> !armed_reg)
    else $error("armed flag survived counter clear");

  // the window opens at timer 4 * (7 - window); an armed clear from there is safe
  a_open_clear: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (clr_seen && armed_reg && !timeout && (int'(wtmr_reg) >= 4 * (7 - int'(win_reg)))) |=> !wdog_reset)
    else $error("armed clear in open window punished");

  // status read returns the window timer and armed flag of the capture cycle
  a_status_fields: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (rd_fire && rd_tm) |=> (s_axi_rdata[7:3] == $past(wtmr_reg) && s_axi_rdata[2] == $past(armed_reg)))
    else $error("status read fields wrong");

  // with the mid oscillator chosen, a cycle without its tick leaves the count alone
  a_timebase_source: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
    (tb_reg == wdog_pkg::TB_MF && !mid_freq_osc && !cnt_clear) |=> ($stable(psc_reg) && $stable(wtmr_reg)))
    else $error("counters moved without a selected tick");

endmodule

`default_nettype wire

/* sim/wdog_regs_tb.sv */
// Purpose: self-checking bench for the windowed watchdog register block
// Assumes: oscillator ticks and clear pulses are one-cycle pulses on core_clk
// Notes:   bus waits are bounded; no latency is assumed beyond the handshake
`timescale 1ns/1ps
`default_nettype none
module wdog_regs_tb;
  // clock, reset, config word
  logic        core_clk, rstn;
  logic [1:0]  wdog_mode_cfg;
  logic [4:0]  cfg_period_field;
  logic [2:0]  cfg_timebase_field, cfg_window_field;
  // ticks, clear, watchdog outputs
  logic        low_freq_osc, mid_freq_osc, wdog_clear_instr, wdog_reset, wdog_active;
  // register bus
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // bookkeeping
  int          fail_count, n_tests, rst_seen, exp_rst;
  logic [31:0] rd;
  logic [1:0]  rs;
  // table rows: {write, byte address, data, response}
  localparam logic [26:0] ROWS [21] = '{
    {1'h0,16'h3B38,8'h07,2'h0}, {1'h0,16'h3B3C,8'h00,2'h0}, {1'h0,16'h3B40,8'h00,2'h0},
    {1'h0,16'h3B44,8'h00,2'h0}, {1'h0,16'h3B34,8'h16,2'h0}, {1'h0,16'h3B44,8'h00,2'h0},
    {1'h1,16'h3B34,8'h00,2'h0}, {1'h0,16'h3B44,8'h00,2'h0}, {1'h0,16'h3B34,8'h00,2'h0},
    {1'h1,16'h3B38,8'h15,2'h0}, {1'h0,16'h3B38,8'h15,2'h0}, {1'h1,16'h3B3C,8'hFF,2'h0},
    {1'h0,16'h3B3C,8'h00,2'h0}, {1'h0,16'h3B48,8'h00,2'h2}, {1'h1,16'h3B48,8'h00,2'h2},
    {1'h0,16'h3B34,8'h0A,2'h0}, {1'h1,16'h3B34,8'h3F,2'h0}, {1'h0,16'h3B34,8'h0B,2'h0},
    {1'h0,16'h3B38,8'h12,2'h0}, {1'h1,16'h3B38,8'h77,2'h0}, {1'h0,16'h3B38,8'h12,2'h0}};
  // period codes with their full count of ticks
  localparam logic [4:0] CODES [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};
  localparam int         TICKS [5] = '{32, 64, 128, 32, 32};

  wdog_regs DUT (.core_clk(core_clk), .rstn(rstn), .wdog_mode_cfg(wdog_mode_cfg),
    .cfg_period_field(cfg_period_field), .cfg_timebase_field(cfg_timebase_field),
    .cfg_window_field(cfg_window_field), .low_freq_osc(low_freq_osc), .mid_freq_osc(mid_freq_osc),
    .wdog_clear_instr(wdog_clear_instr), .wdog_reset(wdog_reset), .wdog_active(wdog_active),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // free-running clock, 8 ns period
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  // count watchdog reset pulses; one-cycle pulse so sample every edge
  always @(posedge core_clk) begin
    if (wdog_reset === 1'h1) rst_seen <= rst_seen + 1;
  end

  // hang guard, generous against a few thousand cycles of tests
  initial begin
    #300000;
    fail_count++;
    $display("BAD t=%0t watchdog of the bench ran out", $time);
    stop_test();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // config reset copies are taken at release, so it changes under reset
  task automatic do_reset(input logic [1:0] m, input logic [4:0] p, input logic [2:0] t, input logic [2:0] w);
    @(posedge core_clk);
    rstn <= 1'h0;
    wdog_mode_cfg <= m;
    cfg_period_field <= p;
    cfg_timebase_field <= t;
    cfg_window_field <= w;
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (4) @(posedge core_clk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] resp);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok) && n < 64) begin
      @(posedge core_clk);
      n++;
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    // the taking edge never shows bvalid yet, so wait at least one more
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 64);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    check(32'(n < 64), 32'h1, "write handshake");
  endtask

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_arready !== 1'h1 && n < 64);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 64);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    check(32'(n < 64), 32'h1, "read handshake");
  endtask

  // n one-cycle pulses, then room for a reset pulse to land
  task automatic pulse(input int n, input logic lf, input logic mf, input logic clr);
    repeat (n) begin
      @(posedge core_clk);
      low_freq_osc <= lf;
      mid_freq_osc <= mf;
      wdog_clear_instr <= clr;
      @(posedge core_clk);
      low_freq_osc <= 1'h0;
      mid_freq_osc <= 1'h0;
      wdog_clear_instr <= 1'h0;
    end
    repeat (2) @(posedge core_clk);
  endtask

  // enable with a period code, one tick short, then the last tick
  task automatic period_run(input logic [4:0] code, input int ticks, input logic lf, input logic mf);
    axi_wr(16'h3B34, {2'h0, code, 1'h1}, rs);
    pulse(ticks - 1, lf, mf, 1'h0);
    check(rst_seen, exp_rst, "early timeout");
    pulse(1, lf, mf, 1'h0);
    exp_rst++;
    check(rst_seen, exp_rst, "timeout missing");
  endtask

  task automatic run_row(input logic [26:0] rw);
    if (rw[26]) axi_wr(rw[25:10], rw[9:2], rs);
    else begin
      axi_rd(rw[25:10], rd, rs);
      check(rd, {24'h000000, rw[9:2]}, "read data");
    end
    check({30'h0, rs}, {30'h0, rw[1:0]}, "response");
  endtask

  initial begin
    {rstn, low_freq_osc, mid_freq_osc, wdog_clear_instr} = 4'h0;
    {wdog_mode_cfg, cfg_period_field, cfg_timebase_field, cfg_window_field} = 13'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hF;
    // soft mode, every field writable
    do_reset(2'h1, 5'h1F, 3'h7, 3'h7);
    for (int i = 0; i < 15; i++) run_row(ROWS[i]);
    $display("register table, writable config done");
    // soft enable off: nothing counts; then mid osc selected
    pulse(40, 1'h1, 1'h1, 1'h0);
    check(rst_seen, exp_rst, "counted while off");
    check({31'h0, wdog_active}, 32'h0, "active while off");
    period_run(5'h00, 32, 1'h0, 1'h1);
    check({31'h0, wdog_active}, 32'h1, "soft enable");
    pulse(40, 1'h1, 1'h0, 1'h0);
    check(rst_seen, exp_rst, "low osc counted");
    axi_wr(16'h3B38, 8'h07, rs);
    for (int i = 0; i < 5; i++) period_run(CODES[i], TICKS[i], 1'h1, 1'h0);
    // restart after timeout without any write
    pulse(31, 1'h1, 1'h0, 1'h0);
    check(rst_seen, exp_rst, "no restart");
    pulse(1, 1'h1, 1'h0, 1'h0);
    exp_rst++;
    check(rst_seen, exp_rst, "second timeout");
    // prescale counter split across three registers, code 10
    axi_wr(16'h3B34, 8'h15, rs);
    pulse(260, 1'h1, 1'h0, 1'h0);
    axi_rd(16'h3B3C, rd, rs);
    check(rd, 32'h04, "prescale low");
    axi_rd(16'h3B40, rd, rs);
    check(rd, 32'h01, "prescale high");
    axi_wr(16'h3B38, 8'h00, rs);
    axi_rd(16'h3B3C, rd, rs);
    check(rd, 32'h00, "ctrl1 write clears");
    $display("periods and timebase done");
    // narrowest window, code 0: open from timer 28
    axi_wr(16'h3B34, 8'h01, rs);
    axi_rd(16'h3B34, rd, rs);
    pulse(5, 1'h1, 1'h0, 1'h0);
    pulse(1, 1'h0, 1'h0, 1'h1);
    exp_rst++;
    check(rst_seen, exp_rst, "closed window clear");
    axi_rd(16'h3B34, rd, rs);
    pulse(29, 1'h1, 1'h0, 1'h0);
    axi_rd(16'h3B44, rd, rs);
    check(rd, 32'hEC, "timer status");
    pulse(1, 1'h0, 1'h0, 1'h1);
    check(rst_seen, exp_rst, "valid clear");
    pulse(29, 1'h1, 1'h0, 1'h0);
    pulse(1, 1'h0, 1'h0, 1'h1);
    exp_rst++;
    check(rst_seen, exp_rst, "unarmed clear");
    // window code 6: open from timer 4, closed below it
    axi_wr(16'h3B38, 8'h06, rs);
    axi_rd(16'h3B34, rd, rs);
    pulse(4, 1'h1, 1'h0, 1'h0);
    pulse(1, 1'h0, 1'h0, 1'h1);
    check(rst_seen, exp_rst, "wide window clear");
    axi_rd(16'h3B34, rd, rs);
    pulse(3, 1'h1, 1'h0, 1'h0);
    pulse(1, 1'h0, 1'h0, 1'h1);
    exp_rst++;
    check(rst_seen, exp_rst, "wide window closed");
    $display("window done");
    // always on, fields locked to config copies
    do_reset(2'h3, 5'h05, 3'h1, 3'h2);
    for (int i = 15; i < 21; i++) run_row(ROWS[i]);
    check({31'h0, wdog_active}, 32'h1, "always on");
    period_run(5'h00, 1024, 1'h0, 1'h1);
    $display("locked config done");
    // always off: soft enable ignored
    do_reset(2'h0, 5'h1F, 3'h7, 3'h7);
    axi_wr(16'h3B34, 8'h01, rs);
    check({31'h0, wdog_active}, 32'h0, "mode off");
    pulse(40, 1'h1, 1'h0, 1'h0);
    pulse(1, 1'h0, 1'h0, 1'h1);
    check(rst_seen, exp_rst, "counted in mode off");
    $display("mode off done");
    stop_test();
  end
endmodule
`default_nettype wire
